// [common/pbu_defines.svh]
// Register offsets, reset values, mode codes and field positions
`ifndef PBU_DEFINES_SVH
`define PBU_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define PBU_ADDR_W 8
`define PBU_OFS_TRUE_COLOR 8'h18
`define PBU_OFS_MUX_CTRL 8'h19
`define PBU_OFS_STATUS 8'h1A
`define PBU_OFS_ORDER_CTRL 8'h1B

`define PBU_RST_TRUE_COLOR 8'h80
`define PBU_RST_MUX_CTRL 8'h00
`define PBU_RST_ORDER_CTRL 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define PBU_STAT_CFG_OK 0
`define PBU_STAT_BUSY 1
`define PBU_STAT_OVERRUN 2
`define PBU_ORDER_BIG_ENDIAN 0

// ****************************************************************
// Mode codes
// ****************************************************************
`define PBU_TC_PSEUDO 8'h80
`define PBU_SUB_LEGACY 4'h0
`define PBU_SUB_FIRST 4'h1
`define PBU_SUB_LAST 4'hC
`define PBU_MUX_BUS16 8'h52
`define PBU_MUX_BUS32 8'h53
`define PBU_MUX_BUS64 8'h54
`define PBU_MUX_W32_BUS32 8'h5B
`define PBU_MUX_W32_BUS64 8'h5C
`define PBU_TC_XRGB32 8'h46
`define PBU_TC_BGRX32 8'h47

// ****************************************************************
// Widths
// ****************************************************************
`define PBU_BUS_W 64
`define PBU_CNT_W 5

`endif

// [common/pbu_pkg.sv]
// Types shared by the pixel bus load unpacker
package pbu_pkg;

   typedef enum logic [1:0] {
      PBU_W4 = 2'h0,
      PBU_W8 = 2'h1,
      PBU_W16 = 2'h3,
      PBU_W32 = 2'h2
   } pbu_width_type;

   typedef logic [4:0] pbu_count_type;

endpackage

// [design/pbu_sync2.sv]
// Two-flop synchroniser for levels and quasi-static words
`timescale 1ns/1ps

module pbu_sync2 #(
   parameter int W = 1
) (
   input wire logic i_clk,            // Destination clock
   input wire logic i_reset_n,        // Asynchronous reset, active low
   input wire logic [W-1:0] i_d,      // Signal from another domain
   output logic [W-1:0] o_q           // Synchronised copy
);

   logic [W-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta <= '0;
         o_q <= '0;
      end else begin
         meta <= i_d;
         o_q <= meta;
      end
   end

endmodule // pbu_sync2

// [design/pbu_unpacker.sv]
// Pixel bus load unpacker: registers, mode decode and pixel shifter
`timescale 1ns/1ps

`include "pbu_defines.svh"

module pbu_unpacker (
   input wire logic i_mclk,                  // Register clock, 40 MHz
   input wire logic i_reset_n,               // Asynchronous reset
   input wire logic [7:0] i_reg_addr,        // Register address
   input wire logic [7:0] i_reg_wdata,       // Register write data
   input wire logic i_reg_wr,                // Write strobe
   input wire logic i_reg_rd,                // Read strobe
   output logic [7:0] o_reg_rdata,           // Read data, cycle after read
   input wire logic i_pix_clk,               // Pixel (link) clock
   input wire logic i_pixel_load_strobe,     // Load clock pin
   input wire logic [63:0] i_pixel_bus,      // Multiplexed pixel bus
   input wire logic [7:0] i_legacy_pixel_port, // Legacy 8-bit port
   output logic [31:0] o_pixel_data,         // Current pixel, low bits
   output pbu_pkg::pbu_width_type o_pixel_width, // Width of o_pixel_data
   output logic o_pixel_valid                // Pixel present this clock
);

   import pbu_pkg::*;

   // ****************************************************************
   // Register file (i_mclk)
   // ****************************************************************
   logic [7:0] true_color_control;
   logic [7:0] multiplex_control;
   logic [7:0] order_control;
   logic overrun_flag;
   logic busy_m;
   logic ovr_tgl_m;
   logic ovr_tgl_seen;
   logic ovr_event;

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         true_color_control <= `PBU_RST_TRUE_COLOR;
         multiplex_control <= `PBU_RST_MUX_CTRL;
         order_control <= `PBU_RST_ORDER_CTRL;
      end else if (i_reg_wr) begin
         unique case (i_reg_addr)
            `PBU_OFS_TRUE_COLOR: true_color_control <= i_reg_wdata;
            `PBU_OFS_MUX_CTRL: multiplex_control <= i_reg_wdata;
            `PBU_OFS_ORDER_CTRL: order_control <= i_reg_wdata;
            default: ;
         endcase
      end
   end

   // Overrun arrives as a toggle from the pixel domain
   assign ovr_event = ovr_tgl_m ^ ovr_tgl_seen;

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ovr_tgl_seen <= 1'b0;
      end else begin
         ovr_tgl_seen <= ovr_tgl_m;
      end
   end

   // Write one clears; a new event in the same cycle wins
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         overrun_flag <= 1'b0;
      end else if (ovr_event) begin
         overrun_flag <= 1'b1;
      end else if (i_reg_wr && i_reg_addr == `PBU_OFS_STATUS &&
                   i_reg_wdata[`PBU_STAT_OVERRUN]) begin
         overrun_flag <= 1'b0;
      end
   end

   // ****************************************************************
   // Mode decode (i_mclk)
   // ****************************************************************
   // Decode only yields the latching shape; the loop clock is set
   // elsewhere by software and is not driven from here
   pbu_width_type next_width;
   pbu_count_type next_count;
   logic next_ok;
   logic next_nib_swap;
   logic next_half_swap;
   logic next_byte_rev;
   logic next_legacy;
   logic [3:0] sub;

   always_comb begin
      next_width = PBU_W8;
      next_count = 5'h00;
      next_ok = 1'b0;
      next_nib_swap = 1'b0;
      next_half_swap = 1'b0;
      next_byte_rev = 1'b0;
      next_legacy = 1'b0;
      sub = multiplex_control[3:0];
      if (true_color_control == `PBU_TC_PSEUDO &&
          multiplex_control[7:4] == 4'h0) begin
         // Legacy port plus twelve submodes
         if (sub == `PBU_SUB_LEGACY) begin
            next_ok = 1'b1;
            next_legacy = 1'b1;
            next_count = 5'h01;
         end else if (sub >= `PBU_SUB_FIRST && sub <= `PBU_SUB_LAST) begin
            next_ok = 1'b1;
            // s1-s8 are 4-bit pixels, s5-s8 swap nibbles per byte
            if (sub <= 4'h8) begin
               next_width = PBU_W4;
               next_nib_swap = (sub >= 4'h5);
               unique case (sub[1:0])
                  2'h1: next_count = 5'h02;
                  2'h2: next_count = 5'h04;
                  2'h3: next_count = 5'h08;
                  2'h0: next_count = 5'h10;
               endcase
            end else begin
               // s9-s12 are 8-bit pixels; s12 gives eight per load
               next_width = PBU_W8;
               unique case (sub[1:0])
                  2'h1: next_count = 5'h01;
                  2'h2: next_count = 5'h02;
                  2'h3: next_count = 5'h04;
                  2'h0: next_count = 5'h08;
               endcase
            end
         end
      end else if (true_color_control == `PBU_TC_XRGB32 ||
                   true_color_control == `PBU_TC_BGRX32) begin
         next_width = PBU_W32;
         next_byte_rev = (true_color_control == `PBU_TC_BGRX32);
         if (multiplex_control == `PBU_MUX_W32_BUS32) begin
            next_ok = 1'b1;
            next_count = 5'h01;
         end else if (multiplex_control == `PBU_MUX_W32_BUS64) begin
            next_ok = 1'b1;
            next_count = 5'h02;
         end
      end else begin
         unique case (true_color_control)
            8'h45, 8'h44, 8'h43, 8'h41,
            8'h05, 8'h04, 8'h03, 8'h01: begin
               next_width = PBU_W16;
               // Direct colour: little or big-endian pairs
               next_half_swap = order_control[`PBU_ORDER_BIG_ENDIAN];
               if (multiplex_control == `PBU_MUX_BUS16) begin
                  next_ok = 1'b1;
                  next_count = 5'h01;
               end else if (multiplex_control == `PBU_MUX_BUS32) begin
                  next_ok = 1'b1;
                  next_count = 5'h02;
               end else if (multiplex_control == `PBU_MUX_BUS64) begin
                  next_ok = 1'b1;
                  next_count = 5'h04;
               end
            end
            default: ;
         endcase
      end
      // Unlisted combinations latch nothing
      if (!next_ok) begin
         next_count = 5'h00;
      end
   end

   // Registered decode is what crosses to the pixel domain
   logic [11:0] cfg_m;

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cfg_m <= 12'h000;
      end else begin
         cfg_m <= {next_ok, next_legacy, next_byte_rev, next_half_swap,
                   next_nib_swap, next_width, next_count};
      end
   end

   // ****************************************************************
   // Register read port (i_mclk)
   // ****************************************************************
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_rd) begin
         unique case (i_reg_addr)
            `PBU_OFS_TRUE_COLOR: o_reg_rdata <= true_color_control;
            `PBU_OFS_MUX_CTRL: o_reg_rdata <= multiplex_control;
            `PBU_OFS_ORDER_CTRL: o_reg_rdata <= order_control;
            `PBU_OFS_STATUS: o_reg_rdata <= {5'h00, overrun_flag, busy_m,
                                            cfg_m[11]};
            default: o_reg_rdata <= 8'h00;
         endcase
      end else begin
         o_reg_rdata <= 8'h00;
      end
   end

   // ****************************************************************
   // Crossings
   // ****************************************************************
   // Configuration is quasi-static: change it only while idle
   logic [11:0] cfg_p;
   logic [72:0] pin_s;
   logic busy_p;
   logic ovr_tgl_p;

   pbu_sync2 #(.W(12)) u_cfg_sync (
      .i_clk(i_pix_clk),
      .i_reset_n(i_reset_n),
      .i_d(cfg_m),
      .o_q(cfg_p)
   );

   // Strobe and data share one pipeline so they stay aligned
   pbu_sync2 #(.W(73)) u_pin_sync (
      .i_clk(i_pix_clk),
      .i_reset_n(i_reset_n),
      .i_d({i_pixel_load_strobe, i_legacy_pixel_port, i_pixel_bus}),
      .o_q(pin_s)
   );

   pbu_sync2 #(.W(2)) u_back_sync (
      .i_clk(i_mclk),
      .i_reset_n(i_reset_n),
      .i_d({busy_p, ovr_tgl_p}),
      .o_q({busy_m, ovr_tgl_m})
   );

   // ****************************************************************
   // Load capture (i_pix_clk)
   // ****************************************************************
   pbu_count_type cfg_count;
   pbu_width_type cfg_width;
   logic strobe_q;
   logic load_edge;
   logic [63:0] bus_fmt;

   assign cfg_count = cfg_p[4:0];
   assign cfg_width = pbu_width_type'(cfg_p[6:5]);
   assign load_edge = pin_s[72] & ~strobe_q;

   always_ff @(posedge i_pix_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         strobe_q <= 1'b0;
      end else begin
         strobe_q <= pin_s[72];
      end
   end

   // Reorder the whole load once, so shifting is always low-first
   always_comb begin
      bus_fmt = pin_s[63:0];
      if (cfg_p[10]) begin
         bus_fmt = {56'h0, pin_s[71:64]};
      end
      for (int b = 0; b < 8; b++) begin
         if (cfg_p[7]) begin
            bus_fmt[b*8 +: 8] = {bus_fmt[b*8 +: 4], bus_fmt[b*8+4 +: 4]};
         end
      end
      for (int w = 0; w < 2; w++) begin
         if (cfg_p[8]) begin
            bus_fmt[w*32 +: 32] = {bus_fmt[w*32 +: 16],
                                   bus_fmt[w*32+16 +: 16]};
         end
         if (cfg_p[9]) begin
            bus_fmt[w*32 +: 32] = {bus_fmt[w*32 +: 8],
                                   bus_fmt[w*32+8 +: 8],
                                   bus_fmt[w*32+16 +: 8],
                                   bus_fmt[w*32+24 +: 8]};
         end
      end
   end

   // ****************************************************************
   // Pixel shifter (i_pix_clk)
   // ****************************************************************
   logic [63:0] shift_reg;
   pbu_count_type remaining;
   logic [31:0] next_pixel;
   logic [63:0] next_shift;

   always_comb begin
      unique case (cfg_width)
         PBU_W4: begin
            next_pixel = {28'h0, shift_reg[3:0]};
            next_shift = {4'h0, shift_reg[63:4]};
         end
         PBU_W8: begin
            next_pixel = {24'h0, shift_reg[7:0]};
            next_shift = {8'h0, shift_reg[63:8]};
         end
         PBU_W16: begin
            next_pixel = {16'h0, shift_reg[15:0]};
            next_shift = {16'h0, shift_reg[63:16]};
         end
         PBU_W32: begin
            next_pixel = shift_reg[31:0];
            next_shift = {32'h0, shift_reg[63:32]};
         end
      endcase
   end

   // All pixels of a load are taken in one edge
   always_ff @(posedge i_pix_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         shift_reg <= 64'h0;
         remaining <= 5'h00;
      end else if (load_edge) begin
         shift_reg <= bus_fmt;
         remaining <= cfg_count;
      end else if (remaining != 5'h00) begin
         shift_reg <= next_shift;
         remaining <= remaining - 5'h01;
      end
   end

   // One pixel per clock, lowest-numbered bits first
   always_ff @(posedge i_pix_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_pixel_data <= 32'h0;
         o_pixel_valid <= 1'b0;
         o_pixel_width <= PBU_W8;
      end else begin
         o_pixel_valid <= (remaining != 5'h00);
         o_pixel_data <= (remaining != 5'h00) ? next_pixel : 32'h0;
         o_pixel_width <= cfg_width;
      end
   end

   // ****************************************************************
   // Status back to the register side
   // ****************************************************************
   // A load before the previous one drained cuts it short
   always_ff @(posedge i_pix_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ovr_tgl_p <= 1'b0;
         busy_p <= 1'b0;
      end else begin
         busy_p <= (remaining != 5'h00);
         if (load_edge && remaining != 5'h00) begin
            ovr_tgl_p <= ~ovr_tgl_p;
         end
      end
   end

endmodule // pbu_unpacker

// [testbench/pbu_monitor.sv]
// Port checker for the pixel bus load unpacker
`timescale 1ns/1ps

module pbu_monitor (
   input wire logic i_mclk, // Register clock
   input wire logic i_reset_n, // Reset, active low
   input wire logic i_reg_rd, // Read strobe
   input wire logic [7:0] o_reg_rdata, // Read data
   input wire logic i_pix_clk, // Pixel clock
   input wire logic i_pixel_load_strobe, // Load strobe
   input wire logic [31:0] o_pixel_data, // Pixel
   input wire pbu_pkg::pbu_width_type o_pixel_width, // Pixel width
   input wire logic o_pixel_valid // Pixel present
);
   import pbu_pkg::*;
   logic [5:0] burst;

   // Run length of back-to-back pixels
   always_ff @(posedge i_pix_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         burst <= 6'h00;
      end else begin
         burst <= o_pixel_valid ? burst + 6'h01 : 6'h00;
      end
   end

   a_rdata_idle_zero: assert property (
      @(posedge i_mclk) disable iff (!i_reset_n)
      !$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
      else $error("read data outside read answer");
   a_idle_data_zero: assert property (
      @(posedge i_pix_clk) disable iff (!i_reset_n)
      !o_pixel_valid |-> o_pixel_data == 32'h0)
      else $error("pixel data without valid");
   a_valid_has_load: assert property (
      @(posedge i_pix_clk) disable iff (!i_reset_n)
      $rose(o_pixel_valid) |-> $past(i_pixel_load_strobe, 1)
      || $past(i_pixel_load_strobe, 2) || $past(i_pixel_load_strobe, 3)
      || $past(i_pixel_load_strobe, 4) || $past(i_pixel_load_strobe, 5))
      else $error("pixels without a load");
   a_width_steady: assert property (
      @(posedge i_pix_clk) disable iff (!i_reset_n)
      o_pixel_valid && $past(o_pixel_valid) |-> $stable(o_pixel_width))
      else $error("width changed inside a load");
   a_burst_limit: assert property (
      @(posedge i_pix_clk) disable iff (!i_reset_n) burst <= 6'h10)
      else $error("more than sixteen pixels in a row");
   a_nibble_clean: assert property (
      @(posedge i_pix_clk) disable iff (!i_reset_n)
      o_pixel_valid && o_pixel_width == PBU_W4 |-> o_pixel_data[31:4] == 0)
      else $error("4-bit pixel has upper bits");
   a_byte_clean: assert property (
      @(posedge i_pix_clk) disable iff (!i_reset_n)
      o_pixel_valid && o_pixel_width == PBU_W8 |-> o_pixel_data[31:8] == 0)
      else $error("8-bit pixel has upper bits");
   a_half_clean: assert property (
      @(posedge i_pix_clk) disable iff (!i_reset_n)
      o_pixel_valid && o_pixel_width == PBU_W16 |-> o_pixel_data[31:16] == 0)
      else $error("16-bit pixel has upper bits");
endmodule // pbu_monitor

bind pbu_unpacker pbu_monitor mon (.i_mclk, .i_reset_n, .i_reg_rd,
   .o_reg_rdata, .i_pix_clk, .i_pixel_load_strobe, .o_pixel_data,
   .o_pixel_width, .o_pixel_valid);

// [testbench/pbu_ctrl_model.sv]
// Behavioural graphics controller that sends one bus load per request
`timescale 1ns/1ps

module pbu_ctrl_model (
   input wire logic i_pix_clk, // Pixel clock
   input wire logic i_req, // Bench asks for one load
   input wire logic [63:0] i_word, // Packed pixels to send
   output logic o_strobe, // Load strobe
   output logic [63:0] o_bus, // Pixel bus
   output logic o_ack // Load has been sent
);
   logic [1:0] hold;

   initial begin
      o_strobe = 1'b0;
      o_bus = 64'h0;
      o_ack = 1'b0;
      hold = 2'h0;
   end

   // Bus is held three pixel clocks, then inverted so stale data never helps
   always @(posedge i_pix_clk) begin
      if (i_req && !o_ack && !o_strobe) begin
         o_bus <= i_word;
         o_strobe <= 1'b1;
         hold <= 2'h0;
      end else if (o_strobe) begin
         hold <= hold + 2'h1;
         if (hold == 2'h2) begin
            o_strobe <= 1'b0;
            o_bus <= ~o_bus;
            o_ack <= 1'b1;
         end
      end else if (!i_req) begin
         o_ack <= 1'b0;
      end
   end
endmodule // pbu_ctrl_model

// [testbench/pbu_unpacker_bench.sv]
// Self-checking bench for the pixel bus load unpacker
`timescale 1ns/1ps
`include "pbu_defines.svh"

module pbu_unpacker_bench;
   import pbu_pkg::*;
   logic i_mclk, i_reset_n, i_reg_wr, i_reg_rd, i_pix_clk, req, ack;
   logic i_pixel_load_strobe, o_pixel_valid;
   logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, i_legacy_pixel_port, rv;
   logic [63:0] word, i_pixel_bus;
   logic [31:0] o_pixel_data;
   pbu_width_type o_pixel_width;
   int n_errors = 0;
   int check_count = 0;

   pbu_unpacker uut (.i_mclk, .i_reset_n, .i_reg_addr, .i_reg_wdata,
      .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_pix_clk, .i_pixel_load_strobe,
      .i_pixel_bus, .i_legacy_pixel_port, .o_pixel_data, .o_pixel_width,
      .o_pixel_valid);
   pbu_ctrl_model ctrl (.i_pix_clk, .i_req(req), .i_word(word),
      .o_strobe(i_pixel_load_strobe), .o_bus(i_pixel_bus), .o_ack(ack));

   // ************************************************************
   // Clocks, unrelated in phase
   // ************************************************************
   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end
   // Pixel clock stands for the loop clock the host has set up
   initial begin
      i_pix_clk = 1'b0;
      #7;
      forever #40 i_pix_clk = ~i_pix_clk;
   end

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge i_mclk);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_mclk);
      i_reg_wr <= 1'b0;
   endtask

   task automatic rd(logic [7:0] a);
      @(posedge i_mclk);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_mclk);
      i_reg_rd <= 1'b0;
      @(negedge i_mclk);
      rv = o_reg_rdata;
   endtask

   task automatic send();
      int t;
      t = 0;
      @(posedge i_mclk);
      req <= 1'b1;
      while (ack !== 1'b1 && t < 200) begin
         @(posedge i_mclk);
         t++;
      end
      req <= 1'b0;
      while (ack !== 1'b0 && t < 400) begin
         @(posedge i_mclk);
         t++;
      end
   endtask

   // One load in the given mode; pixel i sits at bit i*w of the load, or at bit (i^1)*w when sw is set
   task automatic run(logic [7:0] tc, logic [7:0] mx, int n, int w, bit sw,
      pbu_width_type wt);
      logic [31:0] e;
      int t;
      wr(`PBU_OFS_TRUE_COLOR, tc);
      wr(`PBU_OFS_MUX_CTRL, mx);
      word <= {word[55:0], mx ^ tc};
      repeat (4) @(posedge i_pix_clk);
      send();
      t = 0;
      while (o_pixel_valid !== 1'b1 && t < 20) begin
         @(posedge i_pix_clk);
         #1;
         t++;
      end
      for (int i = 0; i < n; i++) begin
         e = 32'((word >> ((sw ? i ^ 1 : i) * w)) & ((64'h1 << w) - 64'h1));
         if (tc == `PBU_TC_BGRX32) begin
            e = {e[7:0], e[15:8], e[23:16], e[31:24]};
         end
         if (mx == 8'h00) begin
            e = {24'h0, i_legacy_pixel_port};
         end
         chk("pixel", o_pixel_data, e);
         chk("width", o_pixel_width, wt);
         @(posedge i_pix_clk);
         #1;
      end
      chk("valid after load", o_pixel_valid, 1'b0);
   endtask

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      i_reset_n = 1'b0;
      i_reg_wr = 1'b0;
      i_reg_rd = 1'b0;
      i_reg_addr = 8'h00;
      i_reg_wdata = 8'h00;
      i_legacy_pixel_port = 8'hA5;
      req = 1'b0;
      word = 64'hF0E1D2C3B4A59687;
      repeat (12) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      rd(`PBU_OFS_TRUE_COLOR);
      chk("tc reset", rv, `PBU_RST_TRUE_COLOR);
      rd(`PBU_OFS_MUX_CTRL);
      chk("mux reset", rv, `PBU_RST_MUX_CTRL);
      rd(`PBU_OFS_ORDER_CTRL);
      chk("order reset", rv, `PBU_RST_ORDER_CTRL);
      wr(8'h30, 8'hFF);
      rd(8'h30);
      chk("unmapped", rv, 8'h00);
      run(`PBU_TC_PSEUDO, 8'h00, 1, 8, 1'b0, PBU_W8);
      for (int k = 1; k <= 12; k++) begin
         run(`PBU_TC_PSEUDO, 8'(k), k > 8 ? 1 << (k - 9) : 2 << ((k - 1) % 4),
            k > 8 ? 8 : 4, k >= 5 && k <= 8, k > 8 ? PBU_W8 : PBU_W4);
      end
      for (int i = 0; i < 24; i++) begin
         run(8'(64'h4544434105040301 >> (8 * (7 - i / 3))),
            8'(8'h52 + i % 3), 1 << (i % 3), 16, 1'b0, PBU_W16);
      end
      for (int m = 0; m < 4; m++) begin
         run(8'(8'h46 + m / 2), 8'(8'h5B + m % 2), 1 + m % 2, 32, 1'b0,
            PBU_W32);
      end
      wr(`PBU_OFS_ORDER_CTRL, 8'h01);
      run(8'h45, `PBU_MUX_BUS64, 4, 16, 1'b1, PBU_W16);
      wr(`PBU_OFS_ORDER_CTRL, 8'h00);
      rd(`PBU_OFS_STATUS);
      chk("config ok", rv[0], 1'b1);
      chk("busy idle", rv[1], 1'b0);
      run(`PBU_TC_PSEUDO, `PBU_MUX_BUS16, 0, 8, 1'b0, PBU_W8);
      rd(`PBU_OFS_STATUS);
      chk("config bad", rv[0], 1'b0);
      run(`PBU_TC_PSEUDO, 8'h0C, 8, 8, 1'b0, PBU_W8);
      send();
      send();
      repeat (30) @(posedge i_pix_clk);
      rd(`PBU_OFS_STATUS);
      chk("overrun set", rv[2], 1'b1);
      wr(`PBU_OFS_STATUS, 8'h04);
      rd(`PBU_OFS_STATUS);
      chk("overrun clear", rv[2], 1'b0);
      end_sim();
   end

   // Whole run needs well under 200 us
   initial begin
      #500000;
      n_errors++;
      end_sim();
   end
endmodule // pbu_unpacker_bench
